// ==== include/srb_pkg.sv ====
// Shared constants and types of the special register bank.
package srb_pkg;

  // Data and conversion widths.
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int IDX_W = 6;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [IDX_W-1:0] IDX_PTR = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PORT5 = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PORT6 = 6'h06;
  localparam logic [IDX_W-1:0] IDX_PORT7 = 6'h07;
  localparam logic [IDX_W-1:0] IDX_AINSEL = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CCTL = 6'h09;
  localparam logic [IDX_W-1:0] IDX_OCAL = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_RES8 = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_RESHI = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_RESLO = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS_TWO = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS_ONE = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_RAM_LO = 6'h10;
  localparam logic [IDX_W-1:0] IDX_RAM_HI = 6'h3F;
  localparam int RAM_DEPTH = 48;

  // Reset values and masks of implemented bits.
  localparam logic [7:0] PTR_KEEP_MASK = 8'h3F;
  localparam logic [7:0] PTR_POR_VAL = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [0:0] PORT7_RST = 1'h1;
  localparam logic [3:0] AINSEL_RST = 4'h0;
  localparam logic [7:0] CCTL_RST = 8'h00;
  localparam logic [7:0] CCTL_MASK = 8'hFB;
  localparam logic [7:0] OCAL_RST = 8'h00;
  localparam logic [7:0] OCAL_MASK = 8'hF8;
  localparam logic [7:0] IRQ_STATUS_TWO_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_TWO_MASK = 8'h3E;
  localparam logic [7:0] IRQ_STATUS_ONE_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  // AHB-Lite encodings used by the slave.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Reset class seen by the bank in a cycle.
  typedef enum logic [1:0] {
    RC_NONE = 2'b00,
    RC_POWER = 2'b01,
    RC_PINWDT = 2'b10,
    RC_WAKE = 2'b11
  } srb_rcls_e;

  // Bus slave phase.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_BUSY = 1'b1
  } srb_bus_e;

  // Converter control layout, bit 7 first.
  typedef struct packed {
    logic reference_source_select;
    logic [1:0] conv_clock_rate;
    logic conversion_run;
    logic converter_power_down;
    logic spare;
    logic [1:0] channel_select;
  } srb_cctl_s;

  // Offset calibration layout, bit 7 first.
  typedef struct packed {
    logic calibrate_enable;
    logic offset_sign;
    logic [2:0] offset_magnitude;
    logic [2:0] spare;
  } srb_ocal_s;

  // Second interrupt status layout, bit 7 first.
  typedef struct packed {
    logic [1:0] spare_hi;
    logic conversion_done_flag;
    logic comparator_flag;
    logic conversion_wake_enable;
    logic comparator_wake_enable;
    logic pin_change_wake_enable;
    logic spare_lo;
  } srb_irq_status_two_s;

  // First interrupt status layout, bit 7 first.
  typedef struct packed {
    logic low_pulse_underflow_flag;
    logic high_pulse_underflow_flag;
    logic timer_c_overflow_flag;
    logic timer_b_overflow_flag;
    logic timer_a_overflow_flag;
    logic external_irq_flag;
    logic port_change_flag;
    logic main_timer_overflow_flag;
  } srb_irq_status_one_s;

  // A finished conversion from the converter core.
  typedef struct packed {
    logic done;
    logic [RES_W-1:0] value;
  } srb_conv_s;

endpackage : srb_pkg

// ==== src/srb_reset_bank.sv ====
// How it works
// R1: Pointer upper bits clear; lower bits kept on pin/watchdog.
// R2: Port five loads ones, kept on wake.
// R3: Port six loads ones, kept on wake.
// R4: Port seven holds only bit 0, resets one.
// R5: Analog enables clear on reset, kept on wake.
// R6: Converter control clears; wake keeps all but bit 2.
// R7: Converter control fields at documented bit positions.
// R8: Offset calibration clears; fields at bits 7..3.
// R9: Upper result register shows result bits 11..4.
// R10: Upper result register kept across wake.
// R11: High result register: zeros above, bits 11..8.
// R12: Low result register shows bits 7..0, kept.
// R13: Second status holds done, comparator, wake enables.
// R14: Second status clears on reset, kept on wake.
// R15: First status holds eight timer and pin flags.
// R16: First status clears on reset, kept on wake.
// R17: Data RAM kept through pin reset and wake.
// R18: Reset from power-on, pin low, or enabled watchdog.
// R19: Reset class selects initial values same cycle.
`timescale 1ns/1ps
`default_nettype none

module srb_reset_bank (
  // Clock and bus reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  // Reset and wake sources.
  input wire logic por_req,
  input wire logic reset_pin_n,
  input wire logic wdt_enable,
  input wire logic wdt_timeout,
  input wire logic pin_wake,
  // Events from the peripherals.
  input wire srb_pkg::srb_conv_s conv_in,
  input wire logic cmp_event,
  input wire srb_pkg::srb_irq_status_one_s irq1_set,
  // Register contents driven to the rest of the core.
  output var logic [7:0] ptr_o,
  output var logic [7:0] port5_o,
  output var logic [7:0] port6_o,
  output var logic port7_o,
  output var logic [3:0] analog_en_o,
  output var srb_pkg::srb_cctl_s conv_ctl_o,
  output var srb_pkg::srb_ocal_s offset_cal_o,
  output var srb_pkg::srb_irq_status_two_s irq_status2_o,
  output var srb_pkg::srb_irq_status_one_s irq_status1_o
);
  import srb_pkg::*;

  // Bus phase state and the captured address phase.
  srb_bus_e st_r;
  logic [IDX_W-1:0] idx_r;
  logic map_r;
  logic wr_r;
  // Conversion result kept as one twelve-bit word.
  logic [RES_W-1:0] res_r;
  // General purpose data memory; it has no reset on purpose.
  logic [7:0] ram_r [RAM_DEPTH];

  // Address phase decode.
  // SEQ is taken like NONSEQ, since every transfer here is a single word.
  wire acc_req = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
  wire [IDX_W-1:0] idx_in = haddr[7:2];
  wire map_in = (haddr[31:8] == 24'h000000) && (idx_in >= IDX_PTR);
  // Only whole-word transfers are expected, so the size is not decoded.
  wire size_unused = |hsize;

  // Reset class: power-on wins over pin or watchdog, which win over wake.
  // A watchdog timeout counts only while the watchdog is enabled.
  wire pinwdt_req = !reset_pin_n || (wdt_enable && wdt_timeout); // [R18]
  srb_rcls_e rcls;
  assign rcls = por_req ? RC_POWER : (pinwdt_req ? RC_PINWDT : (pin_wake ? RC_WAKE : RC_NONE)); // [R19]
  wire is_hard = (rcls == RC_POWER) || (rcls == RC_PINWDT);

  // A write lands in the data phase; any reset class in that cycle drops it.
  wire wr_stb = (st_r == BUS_BUSY) && wr_r && map_r;
  wire wr_ok = wr_stb && (rcls == RC_NONE);
  wire [7:0] wd = hwdata[7:0];
  // The data memory fills indices 0x10 to 0x3F; ram_idx is only used on a hit.
  wire [IDX_W-1:0] ram_idx = idx_r - IDX_RAM_LO;
  wire ram_hit = (idx_r >= IDX_RAM_LO) && (idx_r <= IDX_RAM_HI);

  // Next value of the pointer; power-on leaves low bits at a fixed value.
  wire [7:0] ptr_hard = (rcls == RC_POWER) ? PTR_POR_VAL : (ptr_o & PTR_KEEP_MASK);
  wire [7:0] ptr_nxt = is_hard ? ptr_hard : ((wr_ok && idx_r == IDX_PTR) ? wd : ptr_o); // [R1]

  // Port data registers; wake simply holds them.
  wire [7:0] port5_nxt = is_hard ? PORT_RST : ((wr_ok && idx_r == IDX_PORT5) ? wd : port5_o); // [R2]
  wire [7:0] port6_nxt = is_hard ? PORT_RST : ((wr_ok && idx_r == IDX_PORT6) ? wd : port6_o); // [R3]
  wire port7_nxt = is_hard ? PORT7_RST[0] : ((wr_ok && idx_r == IDX_PORT7) ? wd[0] : port7_o); // [R4]
  wire [3:0] ain_nxt = is_hard ? AINSEL_RST : ((wr_ok && idx_r == IDX_AINSEL) ? wd[3:0] : analog_en_o); // [R5]

  // Converter control: a finished conversion ends the run bit.
  // Bit 2 is forced to zero by the mask on every path but hard reset, where CCTL_RST is zero.
  srb_cctl_s cctl_done;
  assign cctl_done = {conv_ctl_o.reference_source_select, conv_ctl_o.conv_clock_rate, 1'b0,
                      conv_ctl_o.converter_power_down, conv_ctl_o.spare, conv_ctl_o.channel_select}; // [R7]
  wire [7:0] cctl_run = conv_in.done ? cctl_done : conv_ctl_o;
  wire [7:0] cctl_sw = (wr_ok && idx_r == IDX_CCTL) ? wd : cctl_run;
  wire [7:0] cctl_nxt = is_hard ? CCTL_RST : (cctl_sw & CCTL_MASK); // [R6]

  // Offset calibration keeps only bits 7 to 3.
  wire [7:0] ocal_nxt = is_hard ? OCAL_RST : (((wr_ok && idx_r == IDX_OCAL) ? wd : offset_cal_o) & OCAL_MASK); // [R8]

  // The result is left alone by every reset class; only a conversion loads it.
  wire [RES_W-1:0] res_nxt = conv_in.done ? conv_in.value : res_r; // [R9] [R10] [R12]

  // Flag registers: a hardware set wins over a clearing write in the same cycle.
  // Software may also set a flag by writing a one, which helps in testing.
  wire [7:0] irq_status_two_set = {2'b00, conv_in.done, cmp_event, 4'h0};
  wire [7:0] irq_status_two_base = (wr_ok && idx_r == IDX_IRQ_STATUS_TWO) ? wd : irq_status2_o;
  wire [7:0] irq_status_two_nxt = is_hard ? IRQ_STATUS_TWO_RST : ((irq_status_two_base | irq_status_two_set) & IRQ_STATUS_TWO_MASK); // [R13] [R14]
  wire [7:0] irq_status_one_base = (wr_ok && idx_r == IDX_IRQ_STATUS_ONE) ? wd : irq_status1_o;
  wire [7:0] irq_status_one_nxt = is_hard ? IRQ_STATUS_ONE_RST : (irq_status_one_base | irq1_set); // [R15] [R16]

  // Read selection; unmapped or reserved space reads as zero.
  // The byte is sampled at the end of the wait state, after any write in flight.
  wire [7:0] rd_byte =
    !map_r ? 8'h00 :
    (idx_r == IDX_PTR) ? ptr_o :
    (idx_r == IDX_PORT5) ? port5_o :
    (idx_r == IDX_PORT6) ? port6_o :
    (idx_r == IDX_PORT7) ? {7'h00, port7_o} :
    (idx_r == IDX_AINSEL) ? {4'h0, analog_en_o} :
    (idx_r == IDX_CCTL) ? conv_ctl_o :
    (idx_r == IDX_OCAL) ? offset_cal_o :
    (idx_r == IDX_RES8) ? res_r[11:4] :
    (idx_r == IDX_RESHI) ? {4'h0, res_r[11:8]} :
    (idx_r == IDX_RESLO) ? res_r[7:0] :
    (idx_r == IDX_IRQ_STATUS_TWO) ? irq_status2_o :
    (idx_r == IDX_IRQ_STATUS_ONE) ? irq_status1_o :
    ram_hit ? ram_r[ram_idx] : 8'h00; // [R9] [R11] [R12]

  // Bus slave: every transfer takes one wait state, which removes any
  // read-after-write hazard at the cost of one cycle per access.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= BUS_IDLE;
      idx_r <= 6'h00;
      map_r <= 1'b0;
      wr_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end else begin
      case (st_r)
        // An accepted address phase opens the wait state.
        BUS_IDLE: begin
          if (acc_req && !size_unused | acc_req) begin
            st_r <= BUS_BUSY;
            idx_r <= idx_in;
            map_r <= map_in;
            wr_r <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        // The data phase completes here; read data is loaded for the final edge.
        BUS_BUSY: begin
          st_r <= BUS_IDLE;
          hreadyout <= 1'b1;
          if (!wr_r) begin
            hrdata <= {24'h000000, rd_byte};
          end
        end
        default: begin
          st_r <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // The response is always OKAY, also for unmapped addresses.
  // Kept as a flop so that every bus output comes straight from a register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // Control registers; the bus reset acts as a power-on.
  // The reset-class values themselves come from the next-value wires above.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_o <= PTR_POR_VAL;
      port5_o <= PORT_RST;
      port6_o <= PORT_RST;
      port7_o <= PORT7_RST[0];
      analog_en_o <= AINSEL_RST;
      conv_ctl_o <= CCTL_RST;
      offset_cal_o <= OCAL_RST;
    end else begin
      ptr_o <= ptr_nxt;
      port5_o <= port5_nxt;
      port6_o <= port6_nxt;
      port7_o <= port7_nxt;
      analog_en_o <= ain_nxt;
      conv_ctl_o <= cctl_nxt;
      offset_cal_o <= ocal_nxt;
    end
  end

  // Result and status registers.
  // The result is reset only by the bus reset; no reset class touches it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_r <= RES_RST;
      irq_status2_o <= IRQ_STATUS_TWO_RST;
      irq_status1_o <= IRQ_STATUS_ONE_RST;
    end else begin
      res_r <= res_nxt;
      irq_status2_o <= irq_status_two_nxt;
      irq_status1_o <= irq_status_one_nxt;
    end
  end

  // Data memory: written only by software in a cycle with no reset class.
  // Leaving it out of reset saves area; its power-on content is unknown.
  always_ff @(posedge hclk) begin
    if (wr_ok && ram_hit) begin
      ram_r[ram_idx] <= wd; // [R17]
    end
  end

  // Checks run on the bus clock and are off while the bus reset is low.
  default clocking srb_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Named steps of a reset class event.
  sequence s_hard;
    (rcls == RC_POWER) || (rcls == RC_PINWDT);
  endsequence

  sequence s_pinwdt;
    rcls == RC_PINWDT;
  endsequence

  sequence s_wake_quiet;
    (rcls == RC_WAKE) && !conv_in.done && !cmp_event && (irq1_set == 8'h00);
  endsequence

  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence

  // A read data phase of one register; the data loaded at its edge is checked.
  sequence s_read_at(logic [IDX_W-1:0] ix);
    (st_r == BUS_BUSY) && !wr_r && map_r && (idx_r == ix);
  endsequence

  ptr_upper_a: assert property (s_pinwdt |=> ptr_o[7:6] == 2'b00 && ptr_o[5:0] == $past(ptr_o[5:0])) // [R1]
    else $error("pointer upper bits not cleared or low bits lost");

  port_ones_a: assert property (s_hard |=> port5_o == 8'hFF && port6_o == 8'hFF) // [R2]
    else $error("port data not all ones after reset");

  port_wake_a: assert property ((rcls == RC_WAKE) |=> $stable(port5_o) && $stable(port6_o)) // [R3]
    else $error("port data changed on wake");

  // The second step allows a write or a further reset that landed one cycle earlier.
  port7_bit_a: assert property (s_hard |=> port7_o ##1 ($past(is_hard) || $past(wr_ok) || port7_o == $past(port7_o))) // [R4]
    else $error("single pin port not one after reset");

  ain_wake_a: assert property ((rcls == RC_WAKE) |=> analog_en_o == $past(analog_en_o)) // [R5]
    else $error("analog enables changed on wake");

  cctl_wake_a: assert property (s_wake_quiet |=> conv_ctl_o == ($past(conv_ctl_o) & CCTL_MASK) && !conv_ctl_o[2]) // [R6]
    else $error("converter control wrong after wake");

  run_end_a: assert property (conv_in.done && rcls == RC_NONE && !wr_stb |=> !conv_ctl_o.conversion_run) // [R7]
    else $error("run bit not cleared by finished conversion");

  ocal_clr_a: assert property (s_hard |=> offset_cal_o == OCAL_RST) // [R8]
    else $error("offset calibration not cleared");

  res_wake_a: assert property ((rcls == RC_WAKE) && !conv_in.done |=> res_r == $past(res_r)) // [R10]
    else $error("result changed on wake");

  reshi_read_a: assert property ((st_r == BUS_BUSY) && !wr_r && map_r && idx_r == IDX_RESHI && !conv_in.done
                                  |=> hrdata == {28'h0000000, $past(res_r[11:8])}) // [R11]
    else $error("high result read wrong");

  done_set_a: assert property (conv_in.done && !is_hard |=> irq_status2_o.conversion_done_flag) // [R13]
    else $error("conversion flag lost");

  isr_wake_a: assert property (s_wake_quiet |=> $stable(irq_status2_o) && $stable(irq_status1_o)) // [R14]
    else $error("status changed on wake");

  irq_status_one_set_a: assert property ((irq1_set != 8'h00) && !is_hard |=> (irq_status1_o & $past(irq1_set)) == $past(irq1_set)) // [R15]
    else $error("first status flag lost");

  irq_status_one_clr_a: assert property (!reset_pin_n |=> irq_status1_o == IRQ_STATUS_ONE_RST && port5_o == PORT_RST) // [R16]
    else $error("pin reset did not clear status");

  bus_wait_a: assert property ((st_r == BUS_IDLE) && acc_req |=> s_read_done) // [R19]
    else $error("bus answer not after one wait state");

  // Remaining reset values, wake holds and read paths.
  ptr_por_a: assert property ((rcls == RC_POWER) |=> ptr_o == PTR_POR_VAL) // [R1]
    else $error("pointer not cleared by power-on");

  port7_wake_a: assert property ((rcls == RC_WAKE) |=> $stable(port7_o)) // [R4]
    else $error("single pin port changed on wake");

  ain_clr_a: assert property (s_hard |=> analog_en_o == AINSEL_RST) // [R5]
    else $error("analog enables not cleared");

  cctl_clr_a: assert property (s_hard |=> conv_ctl_o == CCTL_RST) // [R6]
    else $error("converter control not cleared");

  ocal_wake_a: assert property ((rcls == RC_WAKE) |=> $stable(offset_cal_o)) // [R8]
    else $error("offset calibration changed on wake");

  res8_read_a: assert property (s_read_at(IDX_RES8) |=> hrdata == {24'h000000, $past(res_r[11:4])}) // [R9]
    else $error("upper result read wrong");

  reslo_read_a: assert property (s_read_at(IDX_RESLO) |=> hrdata == {24'h000000, $past(res_r[7:0])}) // [R12]
    else $error("low result read wrong");

  cmp_set_a: assert property (cmp_event && !is_hard |=> irq_status2_o.comparator_flag) // [R13]
    else $error("comparator flag lost");

  irq_status_two_clr_a: assert property (s_hard |=> irq_status2_o == IRQ_STATUS_TWO_RST) // [R14]
    else $error("second status not cleared");

  wdt_reset_a: assert property (wdt_enable && wdt_timeout |=> ptr_o[7:6] == 2'b00 && port5_o == PORT_RST) // [R18]
    else $error("enabled watchdog timeout did not reset");

endmodule : srb_reset_bank

`default_nettype wire

// ==== tb/srb_reset_bank_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module srb_reset_bank_test;
  import srb_pkg::*;

  // Bench-driven inputs, all given a value at time zero.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic por_req = 1'b0;
  logic reset_pin_n = 1'b1;
  logic wdt_enable = 1'b0;
  logic wdt_timeout = 1'b0;
  logic pin_wake = 1'b0;
  srb_conv_s conv_in = '0;
  logic cmp_event = 1'b0;
  srb_irq_status_one_s irq1_set = '0;
  // Design outputs.
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [7:0] ptr_o;
  wire logic [7:0] port5_o;
  wire logic [7:0] port6_o;
  wire logic port7_o;
  wire logic [3:0] analog_en_o;
  srb_cctl_s conv_ctl_o;
  srb_ocal_s offset_cal_o;
  srb_irq_status_two_s irq_status2_o;
  srb_irq_status_one_s irq_status1_o;
  // Reference model of every word, with the bits that software may write.
  logic [7:0] m [0:63];
  logic [7:0] wm [0:63];
  logic [31:0] exp_q [$];
  logic [31:0] adr_q [$];
  logic [31:0] cur_adr;
  logic rd_phase = 1'b0;
  logic [31:0] rnd;
  logic [11:0] v;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  srb_reset_bank u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .por_req(por_req), .reset_pin_n(reset_pin_n),
    .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout), .pin_wake(pin_wake), .conv_in(conv_in),
    .cmp_event(cmp_event), .irq1_set(irq1_set), .ptr_o(ptr_o), .port5_o(port5_o), .port6_o(port6_o),
    .port7_o(port7_o), .analog_en_o(analog_en_o), .conv_ctl_o(conv_ctl_o), .offset_cal_o(offset_cal_o),
    .irq_status2_o(irq_status2_o),
    .irq_status1_o(irq_status1_o));

  // The 25 ns clock.
  initial begin
    forever #12.5 hclk = ~hclk;
  end

  // Cuts a hang short; the whole run needs well under two thousand cycles.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // Compares one value and counts it.
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // Watches completed read data phases and checks them against the oldest note.
  always @(posedge hclk) begin
    if (hreadyout === 1'b1) begin
      if (rd_phase && exp_q.size() > 0) begin
        cur_adr = adr_q.pop_front();
        cmp($sformatf("hrdata at %h", cur_adr), exp_q.pop_front(), hrdata);
        cmp("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
      end
      rd_phase <= hsel & htrans[1] & ~hwrite;
    end
  end

  // One single AHB-Lite transfer; the master never assumes a wait count.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : bus

  // Notes the expected word, then reads it.
  task rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    adr_q.push_back(a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Writes an index; read-only and reserved bits stay as the model says.
  task wr(input int i, input logic [7:0] d);
    bus(1'b1, 32'(i * 4), {24'hA5A5A5, d});
    if (wm[i] != 8'h00) m[i] = d & wm[i];
  endtask : wr

  // Reads every register word, unmapped ones included, and some outputs.
  task check_all(input bit ram);
    for (int j = 0; j < 16; j++) rd(32'(j * 4), m[j]);
    if (ram) begin
      rd(32'h40, m[16]);
      rd(32'hFC, m[63]);
      rd(32'h100, 8'h00);
    end
    cmp("ptr_o", {24'h0, m[4]}, {24'h0, ptr_o});
    cmp("port5_o", {24'h0, m[5]}, {24'h0, port5_o});
    cmp("conv_ctl_o", {24'h0, m[9]}, {24'h0, conv_ctl_o});
    cmp("port6_o", {24'h0, m[6]}, {24'h0, port6_o});
    cmp("port7_o", {24'h0, m[7]}, {31'h0, port7_o});
    cmp("analog_en_o", {24'h0, m[8]}, {28'h0, analog_en_o});
    cmp("offset_cal_o", {24'h0, m[10]}, {24'h0, offset_cal_o});
    cmp("irq_status2_o", {24'h0, m[14]}, {24'h0, irq_status2_o});
    cmp("irq_status1_o", {24'h0, m[15]}, {24'h0, irq_status1_o});
  endtask : check_all

  // Hard reset values in the model; the result and the data RAM are kept.
  task apply(input bit por);
    m[4] = por ? 8'h00 : (m[4] & 8'h3F);
    m[5] = 8'hFF;
    m[6] = 8'hFF;
    m[7] = 8'h01;
    m[8] = 8'h00;
    m[9] = 8'h00;
    m[10] = 8'h00;
    m[14] = 8'h00;
    m[15] = 8'h00;
  endtask : apply

  // Raises one reset class or event for one edge: 0 por, 1 pin, 2 wdt, 3 wdt off, 4 wake, 5 events.
  task pulse(input int k);
    case (k)
      0: por_req <= 1'b1;
      1: reset_pin_n <= 1'b0;
      2: begin
        wdt_enable <= 1'b1;
        wdt_timeout <= 1'b1;
      end
      3: wdt_timeout <= 1'b1;
      4: pin_wake <= 1'b1;
      default: begin
        conv_in <= {1'b1, v};
        cmp_event <= 1'b1;
        irq1_set <= rnd[15:8];
      end
    endcase
    @(posedge hclk);
    por_req <= 1'b0;
    reset_pin_n <= 1'b1;
    wdt_enable <= 1'b0;
    wdt_timeout <= 1'b0;
    pin_wake <= 1'b0;
    conv_in <= '0;
    cmp_event <= 1'b0;
    irq1_set <= '0;
    @(posedge hclk);
  endtask : pulse

  // Main sequence.
  initial begin
    rnd = $urandom(65);
    for (int i = 0; i < 64; i++) begin
      m[i] = 8'h00;
      wm[i] = (i >= 16) ? 8'hFF : 8'h00;
    end
    wm[4] = 8'hFF;
    wm[5] = 8'hFF;
    wm[6] = 8'hFF;
    wm[7] = 8'h01;
    wm[8] = 8'h0F;
    wm[9] = 8'hFB;
    wm[10] = 8'hF8;
    wm[14] = 8'h3E;
    wm[15] = 8'hFF;
    apply(1'b1);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_all(1'b0);
    $display("test power_up done");
    // Random writes to indices 2 to 15 and two RAM words, read-only and unmapped places too.
    for (int i = 2; i < 16; i++) begin
      rnd = $urandom;
      wr(i, rnd[7:0] | 8'h04);
    end
    wr(16, 8'h3C);
    wr(63, 8'hC3);
    bus(1'b1, 32'h140, 32'h5A); // Must not alias the first RAM word.
    check_all(1'b1);
    $display("test writes done");
    // A finished conversion together with flag events; the run bit clears.
    rnd = $urandom;
    v = rnd[27:16];
    wr(9, 8'h10);
    pulse(5);
    m[11] = v[11:4];
    m[12] = {4'h0, v[11:8]};
    m[13] = v[7:0];
    m[14] = m[14] | 8'h30;
    m[15] = m[15] | rnd[15:8];
    m[9] = m[9] & 8'hEF;
    check_all(1'b1);
    $display("test conversion done");
    pulse(4);
    check_all(1'b1);
    pulse(3);
    check_all(1'b1);
    $display("test wake and idle watchdog done");
    for (int k = 0; k < 3; k++) begin
      wr(4, 8'hFF);
      wr(5, 8'h12);
      wr(9, 8'hEB);
      pulse(2 - k);
      apply(k == 2);
      check_all(1'b1);
    end
    $display("test reset classes done");
    @(posedge hclk);
    print_verdict();
  end

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    // A read note that was never matched by a completed read is a mismatch too.
    if (exp_q.size() != 0) bad_count++;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

endmodule : srb_reset_bank_test

`default_nettype wire
